// >>> rspc_consts.vh
// Constants for the reset and standby pin control block.
// Assumes inclusion by the design, its checker and its bench.
`ifndef RSPC_CONSTS_VH
`define RSPC_CONSTS_VH

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define RSPC_SEG_W 30
`define RSPC_SEG_LOW 30'h0000_0000
`define RSPC_START_ADDR 16'h0000
`define RSPC_ADDR_W 16

// ----------------------------------------
// State codes
// ----------------------------------------
`define RSPC_ST_RUN 2'h0
`define RSPC_ST_WAIT_CARRY 2'h1
`define RSPC_ST_STOP 2'h2
`define RSPC_ST_HALT 2'h3

`endif

// >>> rspc_reset_ctrl.v
// Reset control unit and standby pin parking for a small controller core.
// Assumes rst_n comes from an analog power-on detector, enable_pin from a pin,
// carry_set_pulse and stop_exec from core logic on mclk.
`timescale 1ns/100ps
`include "rspc_consts.vh"

module rspc_reset_ctrl (
  // Clock and power-on reset
  input wire mclk,
  input wire rst_n,
  // Core side
  input wire enable_pin,
  input wire carry_set_pulse,
  input wire stop_exec,
  input wire pll_enable_req,
  // Internal reset and status outputs
  output reg halt_force_reset_n,
  output reg partial_register_reset_n,
  output reg core_reset_n,
  output reg full_register_reset_n,
  output reg [`RSPC_ADDR_W-1:0] start_addr,
  output wire halted,
  output wire clock_stopped,
  // Segment pins
  output wire segment_mode,
  output wire [`RSPC_SEG_W-1:0] segment_output_pins,
  output wire segment_output_oe,
  // PLL pins
  output wire pll_enabled,
  output wire osc_input_low_band,
  output wire osc_input_high_band,
  output wire osc_input_pulldown_en,
  output wire phase_error_out_a,
  output wire phase_error_out_b,
  output wire phase_error_out_oe,
  // Crystal pins
  output wire crystal_in_pin,
  output wire crystal_in_pulldown_en,
  output wire crystal_out_pin,
  output wire crystal_out_force_en
);

  // ----------------------------------------
  // Enable pin synchroniser and edge detect
  // ----------------------------------------
  reg en_meta_r;
  reg en_sync_r;
  reg en_prev_r;
  wire en_rise;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      en_meta_r <= 1'b0;
      en_sync_r <= 1'b0;
      en_prev_r <= 1'b0;
    end else begin
      en_meta_r <= enable_pin;
      en_sync_r <= en_meta_r;
      en_prev_r <= en_sync_r;
    end
  end

  assign en_rise = en_sync_r & ~en_prev_r;

  // ----------------------------------------
  // Reset control state machine
  // ----------------------------------------
  localparam ST_RUN = `RSPC_ST_RUN;
  localparam ST_WAIT_CARRY = `RSPC_ST_WAIT_CARRY;
  localparam ST_STOP = `RSPC_ST_STOP;
  localparam ST_HALT = `RSPC_ST_HALT;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg por_done_r;

  // Standby decode, shared by reset outputs and status
  function is_standby;
    input [1:0] st;
    begin
      is_standby = (st == ST_STOP) || (st == ST_HALT);
    end
  endfunction

  // power-on is the async reset; the enable pin and stop_exec are the other sources
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (stop_exec)
          state_nxt = ST_STOP;
        else if (en_rise)
          state_nxt = ST_WAIT_CARRY;
      end
      ST_WAIT_CARRY: begin
        if (stop_exec)
          state_nxt = ST_STOP;
        else if (carry_set_pulse)
          state_nxt = ST_RUN;
      end
      ST_STOP: begin
        // Clock stop left only by enable pin rising
        if (en_rise)
          state_nxt = ST_HALT;
      end
      ST_HALT: begin
        if (carry_set_pulse)
          state_nxt = ST_RUN;
      end
      default: state_nxt = ST_RUN;
    endcase
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_HALT;
      por_done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_HALT && carry_set_pulse)
        por_done_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Reset outputs
  // ----------------------------------------
  // Registered so the reset lines never glitch into the core.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      halt_force_reset_n <= 1'b0;
      partial_register_reset_n <= 1'b0;
      core_reset_n <= 1'b0;
      full_register_reset_n <= 1'b0;
      start_addr <= `RSPC_START_ADDR;
    end else begin
      // halt in stop and halt states, partial in stop only; enable from run asserts neither
      halt_force_reset_n <= ~is_standby(state_nxt);
      partial_register_reset_n <= ~(state_nxt == ST_STOP);
      // core reset at carry edge, stop, or halt
      core_reset_n <= ~((state_r == ST_WAIT_CARRY && carry_set_pulse) ||
        is_standby(state_nxt));
      // full clear held until first halt release after power-on
      full_register_reset_n <= por_done_r;
      start_addr <= `RSPC_START_ADDR;
    end
  end

  assign halted = is_standby(state_r);
  assign clock_stopped = (state_r == ST_STOP);

  // ----------------------------------------
  // Standby pin parking
  // ----------------------------------------
  // segments low in clock stop
  assign segment_mode = clock_stopped;
  assign segment_output_pins = `RSPC_SEG_LOW;
  assign segment_output_oe = clock_stopped;

  // PLL off in halt while enable low
  assign pll_enabled = pll_enable_req & ~clock_stopped & ~(halted & ~en_sync_r);

  // oscillator inputs low, error outputs floated while PLL off
  assign osc_input_low_band = 1'b0;
  assign osc_input_high_band = 1'b0;
  assign osc_input_pulldown_en = ~pll_enabled;
  assign phase_error_out_a = 1'b0;
  assign phase_error_out_b = 1'b0;
  assign phase_error_out_oe = pll_enabled;

  assign crystal_in_pin = 1'b0;
  assign crystal_in_pulldown_en = clock_stopped;
  assign crystal_out_pin = 1'b1;
  assign crystal_out_force_en = clock_stopped;

endmodule // rspc_reset_ctrl

// >>> rspc_props.sv
// Checker on the reset control ports.
// Assumes one mclk domain; bound below.
`timescale 1ns/100ps
`include "rspc_consts.vh"
module rspc_props (
  input wire mclk, rst_n, enable_pin, carry_set_pulse, stop_exec, halted, clock_stopped, pll_enabled,
  input wire halt_force_reset_n, partial_register_reset_n, core_reset_n, crystal_out_pin,
  input wire segment_output_oe, osc_input_pulldown_en, phase_error_out_oe, crystal_in_pulldown_en,
  input wire [`RSPC_SEG_W-1:0] segment_output_pins
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_low3; !enable_pin [*3]; endsequence
  sequence s_carry; carry_set_pulse ##1 !core_reset_n; endsequence
  property p_seg; clock_stopped |-> segment_output_oe && segment_output_pins == 0; endproperty
  a_seg: assert property (p_seg) else $error("segments lit");
  property p_pll; s_low3 ##0 halted |-> !pll_enabled; endproperty
  a_pll: assert property (p_pll) else $error("pll on");
  property p_pins; !pll_enabled |-> osc_input_pulldown_en && !phase_error_out_oe; endproperty
  a_pins: assert property (p_pins) else $error("pll pins");
  property p_xtal; clock_stopped |-> crystal_in_pulldown_en && crystal_out_pin; endproperty
  a_xtal: assert property (p_xtal) else $error("crystal pins");
  property p_stop; stop_exec && !halted && !clock_stopped |=> !halt_force_reset_n && !core_reset_n; endproperty
  a_stop: assert property (p_stop) else $error("stop reset");
  property p_core; $fell(core_reset_n) |-> $past(carry_set_pulse) || $past(stop_exec); endproperty
  a_core: assert property (p_core) else $error("core early");
  property p_pulse; s_carry ##0 halt_force_reset_n |=> core_reset_n; endproperty
  a_pulse: assert property (p_pulse) else $error("core width");
  property p_hold; !halt_force_reset_n && !carry_set_pulse |=> !halt_force_reset_n; endproperty
  a_hold: assert property (p_hold) else $error("halt left");
endmodule // rspc_props
bind rspc_reset_ctrl rspc_props i_rspc_props (.*);

// >>> rspc_ce_model.sv
// Outside system driving the enable pin.
// Assumes lvl is the wanted level, reached dly+1 cycles later.
`timescale 1ns/100ps
module rspc_ce_model (
  input wire mclk,
  input wire lvl,
  input wire [3:0] dly,
  output reg enable_pin
);
  reg [3:0] cnt_r = 4'h0;
  initial enable_pin = 1'b0;
  always @(posedge mclk) begin
    cnt_r <= (lvl == enable_pin) ? 4'h0 : cnt_r + 4'h1;
    if (lvl != enable_pin && cnt_r >= dly) enable_pin <= lvl;
  end
endmodule // rspc_ce_model

// >>> tb_rspc_reset_ctrl.sv
// Bench for the reset control block.
// Assumes rspc_props is bound to the design.
`timescale 1ns/100ps
`include "rspc_consts.vh"
module tb_rspc_reset_ctrl;
  reg mclk = 0, rst_n = 0, lvl = 0, carry = 0, stop = 0, pll_req = 0;
  reg [3:0] dly = 4'h0;
  wire en, hr, pr, cr, fr, hl, cs;
  wire [15:0] sa;
  integer error_cnt = 0, check_count = 0, i, n, st = 3, fe = 0;
  always #4 mclk = ~mclk;
  rspc_ce_model i_rspc_ce_model (.mclk(mclk), .lvl(lvl), .dly(dly), .enable_pin(en));
  rspc_reset_ctrl i_rspc_reset_ctrl (.mclk(mclk), .rst_n(rst_n), .enable_pin(en), .carry_set_pulse(carry),
    .stop_exec(stop), .pll_enable_req(pll_req), .halt_force_reset_n(hr), .partial_register_reset_n(pr),
    .core_reset_n(cr), .full_register_reset_n(fr), .start_addr(sa), .halted(hl), .clock_stopped(cs),
    .segment_mode(), .segment_output_pins(), .segment_output_oe(), .pll_enabled(), .osc_input_low_band(),
    .osc_input_high_band(), .osc_input_pulldown_en(), .phase_error_out_a(), .phase_error_out_b(),
    .phase_error_out_oe(), .crystal_in_pin(), .crystal_in_pulldown_en(), .crystal_out_pin(),
    .crystal_out_force_en());
  task final_report; begin
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  end endtask
  // Model: 0 run, 2 stop, 3 halt, 4 core pulse
  task chk; reg [20:0] e; begin
    e = {fe[0], `RSPC_START_ADDR, st == 0 ? 4'hE : st == 2 ? 4'h1 : st == 3 ? 4'h4 : 4'hC};
    check_count = check_count + 1;
    if ({fr, sa, hr, pr, cr, cs} !== e) begin
      error_cnt = error_cnt + 1;
      $display("unexpected resets exp %h got %h", e, {fr, sa, hr, pr, cr, cs});
    end
  end endtask
  task pulse(input c, input s); begin
    @(posedge mclk);
    carry <= c;
    stop <= s;
    pll_req <= 1'($urandom);
    @(posedge mclk);
    carry <= 1'b0;
    stop <= 1'b0;
    #1;
  end endtask
  task wait_en(input v); begin
    @(posedge mclk);
    lvl <= v;
    dly <= 4'($urandom);
    for (i = 0; i < 40 && en !== v; i = i + 1) @(posedge mclk);
    if (en !== v) error_cnt = error_cnt + 1;
    if (en !== v) final_report;
    repeat (4) @(posedge mclk);
    #1;
  end endtask
  initial begin
    n = $urandom(5585);
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    #1 chk;
    pulse(1'b1, 1'b0);
    st = 0;
    chk;
    fe = 1;
    for (n = 0; n < 3; n = n + 1) begin
      pulse(1'b1, 1'b0);
      chk;
      wait_en(1'b1);
      chk;
      pulse(1'b1, 1'b0);
      st = 4;
      chk;
      @(posedge mclk);
      #1 st = 0;
      chk;
      wait_en(1'b0);
    end
    pulse(1'b0, 1'b1);
    st = 2;
    chk;
    wait_en(1'b1);
    st = 3;
    chk;
    pulse(1'b1, 1'b0);
    st = 0;
    chk;
    final_report;
  end
endmodule // tb_rspc_reset_ctrl
